//--- design/ebac_ctrl.sv
`timescale 1ns/1ps
// What this block does
// - Seven-bit address picks one of 128 bytes
// - Address bit seven reads as zero
// - Control bits seven to three read zero
// - Data register feeds writes, receives reads
// - Arm bit clears itself four cycles later
// - Write strobe starts write only when armed
// - Arm accepted only with strobe written zero
// - Write strobe stays set until write time ends
// - Write start stalls CPU two cycles
// - Read strobe fetches byte, stalls four cycles
// - Read finishes within one instruction
// - Address or data change aborts write
// - Registers sit in CPU I/O space
module ebac_ctrl #(
  parameter int WRITE_CYCLES = ebac_pkg::WRITE_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // CPU I/O-space access
  input wire logic io_sel,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata_ff,
  // CPU halt request
  output logic cpu_stall_ff,
  // Status of last write
  output logic write_aborted_ff
);
  localparam int CW = $clog2(WRITE_CYCLES + 1);

  logic [6:0] addr_ff;
  logic [7:0] data_ff;
  logic arm_ff;
  logic wstb_ff;
  logic [2:0] arm_cnt_ff;
  logic [CW-1:0] wcnt_ff;
  logic [2:0] stall_cnt_ff;
  logic [7:0] mem_ff [ebac_pkg::ARRAY_DEPTH];
  ebac_pkg::ebac_state_t state_ff;

  // Register decode
  wire wr_addr = io_sel && io_wr && (io_addr == ebac_pkg::ADDR_SEL);
  wire wr_data = io_sel && io_wr && (io_addr == ebac_pkg::DATA_SEL);
  wire wr_ctrl = io_sel && io_wr && (io_addr == ebac_pkg::CTRL_SEL);
  wire rd_any = io_sel && io_rd;
  wire set_arm = wr_ctrl && io_wdata[ebac_pkg::ARM_POS]
    && !io_wdata[ebac_pkg::WSTB_POS];
  wire idle = (state_ff == ebac_pkg::EB_IDLE);
  wire start_wr = wr_ctrl && io_wdata[ebac_pkg::WSTB_POS] && arm_ff && idle;
  // A read during a write would race the array, so its strobe is ignored unless idle
  wire start_rd = wr_ctrl && io_wdata[ebac_pkg::RSTB_POS] && idle && !start_wr;
  wire abort_wr = !idle && (wr_addr || wr_data);
  wire wr_done = !idle && (wcnt_ff == CW'(1));
  wire [7:0] ctrl_view = {5'h00, arm_ff, wstb_ff, 1'b0};
  wire [7:0] addr_view = {1'b0, addr_ff};
  wire [7:0] rd_mux = (io_addr == ebac_pkg::ADDR_SEL) ? addr_view :
                      (io_addr == ebac_pkg::DATA_SEL) ? data_ff :
                      (io_addr == ebac_pkg::CTRL_SEL) ? ctrl_view : 8'h00;

  // Next address and data; a read loads data in the strobe cycle
  // A fetch never meets a data write: both come through one access port
  wire [6:0] nxt_addr = wr_addr ? io_wdata[6:0] : addr_ff;
  wire [7:0] rd_byte = mem_ff[addr_ff];
  wire [7:0] nxt_data = wr_data ? io_wdata :
                        start_rd ? rd_byte : data_ff;

  // Address and data registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff <= ebac_pkg::ADDR_RST;
      data_ff <= ebac_pkg::DATA_RST;
    end else begin
      addr_ff <= nxt_addr;
      data_ff <= nxt_data;
    end
  end

  // Arm lifetime; a fresh arm reloads the full window
  // Usable at the four edges after it is taken, refused from the fifth on
  wire arm_last = arm_ff && (arm_cnt_ff == 3'h1);
  wire nxt_arm = set_arm ? 1'b1 : (arm_last ? 1'b0 : arm_ff);
  wire [2:0] nxt_arm_cnt = set_arm ? 3'(ebac_pkg::ARM_CYCLES) :
                           arm_ff ? arm_cnt_ff - 3'h1 : arm_cnt_ff;

  // Arm bit and its down-counter
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      arm_ff <= 1'b0;
      arm_cnt_ff <= 3'h0;
    end else begin
      arm_ff <= nxt_arm;
      arm_cnt_ff <= nxt_arm_cnt;
    end
  end

  // Sequencer state decode
  ebac_pkg::ebac_state_t nxt_state;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ebac_pkg::EB_IDLE: begin
        if (start_wr) nxt_state = ebac_pkg::EB_WRITING;
      end
      ebac_pkg::EB_WRITING: begin
        if (wr_done) nxt_state = ebac_pkg::EB_IDLE;
      end
      default: nxt_state = ebac_pkg::EB_IDLE;
    endcase
  end

  // Write timer, strobe and abort status
  // Counter is a parameter so a model can cut the millisecond write time
  wire [CW-1:0] nxt_wcnt = start_wr ? CW'(WRITE_CYCLES) :
                           !idle ? wcnt_ff - CW'(1) : wcnt_ff;
  wire nxt_wstb = start_wr ? 1'b1 : (wr_done ? 1'b0 : wstb_ff);
  // Status clears only at a new start or reset, so write_aborted_ff holds it afterwards
  wire nxt_aborted = start_wr ? 1'b0 :
                     (abort_wr ? 1'b1 : write_aborted_ff);

  // Self-timed write sequencer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ebac_pkg::EB_IDLE;
      wstb_ff <= 1'b0;
      wcnt_ff <= '0;
      write_aborted_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wstb_ff <= nxt_wstb;
      wcnt_ff <= nxt_wcnt;
      write_aborted_ff <= nxt_aborted;
    end
  end

  // Commit only clean writes; an aborted write leaves the old byte
  // Abort in the last cycle is caught too, so no half-updated byte lands
  wire commit = wr_done && !write_aborted_ff && !abort_wr;

  // Array storage, not reset: contents survive a reset like the real cells
  always_ff @(posedge ref_clk) begin
    if (commit) mem_ff[addr_ff] <= data_ff;
  end

  // CPU halt length and registered read-back
  // Stall rises in the cycle after the strobe and falls after its count
  wire stall_busy = (stall_cnt_ff != 3'h0);
  wire [2:0] nxt_stall_cnt = start_wr ? ebac_pkg::WR_STALL :
                             start_rd ? ebac_pkg::RD_STALL :
                             stall_busy ? stall_cnt_ff - 3'h1 : stall_cnt_ff;
  wire nxt_stall = start_wr || start_rd || (stall_busy && (stall_cnt_ff != 3'h1));
  wire [7:0] nxt_rdata = rd_any ? rd_mux : io_rdata_ff;

  // Stall counter and read data registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stall_cnt_ff <= 3'h0;
      cpu_stall_ff <= 1'b0;
      io_rdata_ff <= 8'h00;
    end else begin
      stall_cnt_ff <= nxt_stall_cnt;
      cpu_stall_ff <= nxt_stall;
      io_rdata_ff <= nxt_rdata;
    end
  end
endmodule : ebac_ctrl

//--- design/ebac_pkg.sv
package ebac_pkg;
  // I/O-space register selects, three locations
  localparam logic [1:0] ADDR_SEL = 2'h0;
  localparam logic [1:0] DATA_SEL = 2'h1;
  localparam logic [1:0] CTRL_SEL = 2'h2;
  // Control field positions
  localparam int ARM_POS = 2;
  localparam int WSTB_POS = 1;
  localparam int RSTB_POS = 0;
  // Reset values
  localparam logic [6:0] ADDR_RST = 7'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  // Array geometry
  localparam int ARRAY_DEPTH = 128;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int ARM_CYCLES = 4;
  localparam logic [2:0] WR_STALL = 3'h2;
  localparam logic [2:0] RD_STALL = 3'h4;
  localparam int WRITE_TIME_US = 2500;
  localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
  // Access sequencer states
  typedef enum logic [1:0] {EB_IDLE, EB_WRITING} ebac_state_t;
endpackage : ebac_pkg

//--- verif/ebac_chk_properties.sv
`timescale 1ns/1ps
module ebac_chk #(parameter int WRITE_CYCLES = 20) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // CPU access
  input wire logic io_sel,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  // Answers
  input wire logic [7:0] io_rdata_ff,
  input wire logic cpu_stall_ff,
  input wire logic write_aborted_ff
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Decoded accesses; codes only, so a refused arm is not mistaken for one
  wire rd = io_sel & io_rd;
  wire cw = io_sel & io_wr & (io_addr == 2'h2);
  wire arm = cw & (io_wdata == 8'h04);
  wire go = cw & (io_wdata == 8'h02);
  addr_msb_a: assert property (rd && io_addr == 2'h0 |=> !io_rdata_ff[7])
    else $error("address msb set");
  ctrl_rsv_a: assert property (rd && io_addr == 2'h2 |=> io_rdata_ff[7:3] == 5'h00)
    else $error("control high bits set");
  read_done_a: assert property (rd && io_addr == 2'h2 |=> !io_rdata_ff[0])
    else $error("read strobe visible");
  write_stall_a: assert property (arm ##2 go |=> cpu_stall_ff[*2] ##1 !cpu_stall_ff)
    else $error("write stall length");
  read_stall_a: assert property (cw && io_wdata == 8'h01 |=> cpu_stall_ff[*4] ##1 !cpu_stall_ff)
    else $error("read stall length");
  arm_expiry_a: assert property (arm ##6 go |=> !cpu_stall_ff)
    else $error("arm outlived its window");
  arm_refuse_a: assert property (cw && io_wdata == 8'h06 ##2 go |=> !cpu_stall_ff)
    else $error("arm taken with strobe");
  abort_flag_a: assert property (arm ##2 go ##[3:8] io_sel && io_wr && io_addr == 2'h1
    |=> write_aborted_ff)
    else $error("abort not flagged");
  // Main scenarios reached
  cover property (arm ##2 go);
  cover property ($rose(write_aborted_ff));
  cover property (cw && io_wdata == 8'h01);
endmodule : ebac_chk

bind ebac_ctrl ebac_chk #(.WRITE_CYCLES(WRITE_CYCLES)) chk (.*);

//--- verif/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t %h %h", $time, g, e); end end
module testbench;
  logic ref_clk = 0, arst_n = 0, io_sel = 0, io_wr = 0, io_rd = 0;
  logic [1:0] io_addr = 2'h0;
  logic [7:0] io_wdata = 8'h00, io_rdata_ff, v;
  logic cpu_stall_ff, write_aborted_ff;
  int n_mismatch = 0, n_tests = 0;
  always #5 ref_clk = ~ref_clk;
  ebac_ctrl #(.WRITE_CYCLES(20)) dut (.*);
  // One-cycle access; v holds the answer once it has landed
  task automatic acc(input logic r, input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {io_sel, io_rd, io_wr, io_addr, io_wdata} <= {1'b1, r, !r, a, d};
    @(posedge ref_clk);
    {io_sel, io_rd, io_wr} <= 3'h0;
    #1 v = io_rdata_ff;
  endtask : acc
  // Wait out the stall, then poll the write strobe under a bound
  task automatic poll;
    repeat (2) @(posedge ref_clk);
    v = 8'hff;
    for (int i = 0; i < 60 && v[1] !== 1'b0; i++) acc(1, 2'h2, 8'h00);
    if (v[1] !== 1'b0) begin
      n_mismatch++;
      give_verdict;
    end
  endtask : poll
  // Byte fetch; bench idles through the four stalled cycles
  task automatic fetch;
    acc(0, 2'h2, 8'h01);
    repeat (4) @(posedge ref_clk);
    acc(1, 2'h1, 8'h00);
  endtask : fetch
  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    acc(1, 2'h2, 8'h00); `CHK(v, 8'h00)
    acc(0, 2'h0, 8'hff);
    acc(1, 2'h0, 8'h00); `CHK(v, 8'h7f)
    acc(1, 2'h3, 8'h00); `CHK(v, 8'h00)
    acc(0, 2'h1, 8'ha5);
    acc(0, 2'h2, 8'h04);
    acc(0, 2'h2, 8'h02);
    repeat (2) @(posedge ref_clk);
    acc(1, 2'h2, 8'h00); `CHK(v, 8'h02)
    poll;
    acc(0, 2'h1, 8'h3c);
    fetch; `CHK(v, 8'ha5)
    acc(0, 2'h1, 8'h3c);
    acc(0, 2'h2, 8'h02);
    acc(1, 2'h2, 8'h00); `CHK(v, 8'h00)
    acc(0, 2'h2, 8'h06);
    acc(0, 2'h2, 8'h02);
    acc(1, 2'h2, 8'h00); `CHK(v, 8'h00)
    acc(0, 2'h2, 8'h04);
    repeat (4) @(posedge ref_clk);
    acc(0, 2'h2, 8'h02);
    acc(1, 2'h2, 8'h00); `CHK(v, 8'h00)
    fetch; `CHK(v, 8'ha5)
    acc(0, 2'h2, 8'h04);
    acc(0, 2'h2, 8'h02);
    repeat (2) @(posedge ref_clk);
    acc(0, 2'h1, 8'h11); `CHK(write_aborted_ff, 1'b1)
    poll;
    give_verdict;
  end
endmodule : testbench
